//--- src/fcs_pkg.sv
// Package with command codes, unlock addresses, pin carriers and timing counts for the flash host sequencer
package fcs_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  // Unlock and command codes
  localparam logic [7:0] CODE_UNLOCK1  = 8'haa;
  localparam logic [7:0] CODE_UNLOCK2  = 8'h55;
  localparam logic [7:0] CODE_PROGRAM  = 8'ha0;
  localparam logic [7:0] CODE_ERASE    = 8'h80;
  localparam logic [7:0] CODE_CHIP     = 8'h10;
  localparam logic [7:0] CODE_SECTOR   = 8'h30;
  localparam logic [7:0] CODE_RESUME   = 8'h30;
  localparam logic [7:0] CODE_SUSPEND  = 8'hb0;
  localparam logic [7:0] CODE_IDENT    = 8'h90;
  localparam logic [7:0] CODE_PROTECT  = 8'h20;
  localparam logic [7:0] CODE_RESET    = 8'hf0;
  // Unlock addresses: byte mode needs twelve bits, the device decodes only the low eleven
  localparam logic [11:0] WORD_ADDR_A  = 12'h555;
  localparam logic [11:0] WORD_ADDR_B  = 12'h2aa;
  localparam logic [11:0] BYTE_ADDR_A  = 12'haaa;
  localparam logic [11:0] BYTE_ADDR_B  = 12'h555;
  localparam logic [10:0] PROT_VERIFY  = 11'h002;
  // Identifier reads: bit zero picks maker or device code
  localparam logic [1:0] ID_MAKER_LOW  = 2'h0;
  localparam logic [1:0] ID_DEVICE_LOW = 2'h1;
  // Status bits in read data
  localparam int BIT_POLL   = 7;
  localparam int BIT_TOGGLE = 6;
  localparam int BIT_LIMIT  = 5;
  // Bus cycle timing: each phase of a write or read lasts PHASE_NS
  localparam int CLK_MHZ   = 40;
  localparam int PHASE_NS  = 100;
  localparam int PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] PHASE_LAST = 4'(PHASE_CYC - 1);
  // Host operations
  typedef enum logic [3:0] {
    FCS_OP_RESET, FCS_OP_PROGRAM, FCS_OP_CHIP_ERASE, FCS_OP_SECTOR_ERASE,
    FCS_OP_SUSPEND, FCS_OP_RESUME, FCS_OP_IDENT, FCS_OP_PROTECT_UNLOCK, FCS_OP_READ
  } fcs_op_t;
  // Request from the user side
  typedef struct packed {
    fcs_op_t           op;
    logic              byte_mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcs_req_t;
  // One bus cycle on the flash pins
  typedef struct packed {
    logic              is_write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcs_cycle_t;
endpackage : fcs_pkg

//--- src/fcs_seq_rom.sv
`timescale 1ns/1ps
// Small table that yields the bus cycle for a given operation and step
module fcs_seq_rom (
  // Clock
  input  wire logic                   clk,
  // Lookup
  input  wire fcs_pkg::fcs_req_t      req,
  input  wire logic [2:0]             step,
  // Result, registered
  output fcs_pkg::fcs_cycle_t         cyc_ff,
  output logic [2:0]                  len_ff
);
  logic [11:0] adr_a;
  logic [11:0] adr_b;
  logic [7:0]  code;
  fcs_pkg::fcs_cycle_t nxt_cyc;
  logic [2:0]  nxt_len;

  // Byte mode swaps the unlock addresses, data codes stay the same
  assign adr_a = req.byte_mode ? fcs_pkg::BYTE_ADDR_A : fcs_pkg::WORD_ADDR_A;
  assign adr_b = req.byte_mode ? fcs_pkg::BYTE_ADDR_B : fcs_pkg::WORD_ADDR_B;

  // Decode operation and step into one bus cycle
  always_comb begin
    nxt_cyc = '0;
    nxt_len = 3'h1;
    code = 8'h00;
    nxt_cyc.is_write = 1'b1;
    unique case (req.op)
      fcs_pkg::FCS_OP_RESET: begin
        nxt_cyc.data = {8'h00, fcs_pkg::CODE_RESET};
      end
      fcs_pkg::FCS_OP_SUSPEND: begin
        nxt_cyc.data = {8'h00, fcs_pkg::CODE_SUSPEND};
      end
      fcs_pkg::FCS_OP_RESUME: begin
        nxt_cyc.data = {8'h00, fcs_pkg::CODE_RESUME};
      end
      fcs_pkg::FCS_OP_READ: begin
        nxt_cyc.is_write = 1'b0;
        nxt_cyc.addr = req.addr;
      end
      default: begin
        // Multi-cycle sequences: third code and length depend on the operation
        unique case (req.op)
          fcs_pkg::FCS_OP_PROGRAM: begin code = fcs_pkg::CODE_PROGRAM; nxt_len = 3'h4; end
          fcs_pkg::FCS_OP_IDENT:   begin code = fcs_pkg::CODE_IDENT;   nxt_len = 3'h4; end
          default:                 begin code = fcs_pkg::CODE_ERASE;   nxt_len = 3'h6; end
        endcase
        unique case (step)
          3'h0, 3'h3: nxt_cyc.data = {8'h00, fcs_pkg::CODE_UNLOCK1};
          3'h1, 3'h4: nxt_cyc.data = {8'h00, fcs_pkg::CODE_UNLOCK2};
          3'h2:       nxt_cyc.data = {8'h00, code};
          default:    nxt_cyc.data = '0;
        endcase
        // High address bits 12 to 16 stay zero; bits 0 to 11 carry the pattern
        unique case (step)
          3'h0, 3'h2, 3'h3: nxt_cyc.addr = {5'h00, adr_a};
          3'h1, 3'h4:       nxt_cyc.addr = {5'h00, adr_b};
          default:          nxt_cyc.addr = '0;
        endcase
        // Last cycle of each sequence
        if (step == 3'h3 && req.op == fcs_pkg::FCS_OP_PROGRAM) begin
          nxt_cyc.addr = req.addr;
          nxt_cyc.data = req.data;
        end else if (step == 3'h3 && req.op == fcs_pkg::FCS_OP_IDENT) begin
          nxt_cyc.is_write = 1'b0;
          nxt_cyc.addr = req.addr;
        end else if (step == 3'h5) begin
          unique case (req.op)
            fcs_pkg::FCS_OP_CHIP_ERASE: begin
              nxt_cyc.addr = {5'h00, adr_a};
              nxt_cyc.data = {8'h00, fcs_pkg::CODE_CHIP};
            end
            fcs_pkg::FCS_OP_SECTOR_ERASE: begin
              nxt_cyc.addr = req.addr;
              nxt_cyc.data = {8'h00, fcs_pkg::CODE_SECTOR};
            end
            default: begin
              nxt_cyc.addr = {5'h00, adr_a};
              nxt_cyc.data = {8'h00, fcs_pkg::CODE_PROTECT};
            end
          endcase
        end
      end
    endcase
  end

  // Registered table output
  always_ff @(posedge clk) begin
    cyc_ff <= nxt_cyc;
    len_ff <= nxt_len;
  end
endmodule : fcs_seq_rom

//--- src/fcs_host.sv
`timescale 1ns/1ps
// Host controller that issues command sequences and polls status on a parallel flash
// How it works
// - Program sends two unlocks, A0 set-up, then location and value.
// - Reset is a single F0 write to any address.
// - Chip erase is six writes ending 555/10.
// - Sector erase ends with 30 to an address inside the sector.
// - Suspend is B0 anywhere, resume is 30 anywhere.
// - Protect unlock is the five erase writes then 555/20.
// - Byte mode uses AAA for 555 and 555 for 2AA.
// - Unlock patterns use address bits 0 to 11; the device decodes only bits 0 to 10.
module fcs_host (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // User request
  input  wire logic                        req_valid,
  input  wire fcs_pkg::fcs_req_t           req,
  output logic                             req_ready,
  // User answer
  output logic                             done_ff,
  output logic                             fail_ff,
  output logic [fcs_pkg::DATA_W-1:0]       rdata_ff,
  // Flash pins
  output logic [fcs_pkg::ADDR_W-1:0]       flash_addr_ff,
  output logic [fcs_pkg::DATA_W-1:0]       flash_dq_out_ff,
  output logic                             flash_dq_oe_n_ff,
  input  wire logic [fcs_pkg::DATA_W-1:0]  flash_dq_in,
  output logic                             flash_ce_n_ff,
  output logic                             flash_oe_n_ff,
  output logic                             flash_we_n_ff
);
  typedef enum logic [2:0] {
    FCS_IDLE, FCS_LOOK, FCS_SETUP, FCS_STROBE, FCS_HOLD, FCS_SAMPLE, FCS_POLL
  } fcs_state_t;

  fcs_state_t               state_ff;
  fcs_pkg::fcs_req_t        req_ff;
  fcs_pkg::fcs_cycle_t      cyc;
  logic [2:0]               len;
  logic [2:0]               step_ff;
  logic [3:0]               tick_ff;
  logic                     tick_end;
  logic                     polling_ff;
  logic                     have_prev_ff;
  logic                     prev_tog_ff;
  logic                     prev_lim_ff;
  logic [fcs_pkg::DATA_W-1:0] dq_s1_ff;
  logic [fcs_pkg::DATA_W-1:0] dq_s2_ff;
  logic [fcs_pkg::DATA_W-1:0] rd_cap_ff;
  logic                     last_step;
  logic                     is_busy_op;
  logic                     toggled;

  // Sequence table, registered lookup
  fcs_seq_rom u_rom (
    .clk    (clk),
    .req    (req_ff),
    .step   (step_ff),
    .cyc_ff (cyc),
    .len_ff (len)
  );

  assign tick_end   = (tick_ff == fcs_pkg::PHASE_LAST);
  assign last_step  = (step_ff == len - 3'h1);
  assign is_busy_op = (req_ff.op == fcs_pkg::FCS_OP_PROGRAM) ||
                      (req_ff.op == fcs_pkg::FCS_OP_CHIP_ERASE) ||
                      (req_ff.op == fcs_pkg::FCS_OP_SECTOR_ERASE);
  // Commands wait while a program or erase is polled, so none reach a busy decoder
  assign req_ready  = (state_ff == FCS_IDLE);
  assign toggled    = rd_cap_ff[fcs_pkg::BIT_TOGGLE] != prev_tog_ff;

  // Read data enters from another domain and passes two flops
  always_ff @(posedge clk) begin
    dq_s1_ff <= flash_dq_in;
    dq_s2_ff <= dq_s1_ff;
  end

  // Read data taken at the strobe rise, while the bus still holds it; later it floats
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_cap_ff <= '0;
    end else if (state_ff == FCS_HOLD && tick_ff == 4'h0) begin
      rd_cap_ff <= dq_s2_ff;
    end
  end

  // Phase timer paces every pin phase
  always_ff @(posedge clk) begin
    if (sys_rst || state_ff == FCS_IDLE || state_ff == FCS_LOOK || state_ff == FCS_SAMPLE ||
        state_ff == FCS_POLL || tick_end) begin
      tick_ff <= 4'h0;
    end else begin
      tick_ff <= tick_ff + 4'h1;
    end
  end

  // Main sequencer: step through table cycles, then poll busy operations
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff   <= FCS_IDLE;
      req_ff     <= '0;
      step_ff    <= 3'h0;
      polling_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        FCS_IDLE: begin
          if (req_valid) begin
            req_ff     <= req;
            step_ff    <= 3'h0;
            polling_ff <= 1'b0;
            state_ff   <= FCS_LOOK;
          end
        end
        FCS_LOOK: state_ff <= FCS_SETUP;
        FCS_SETUP: if (tick_end) state_ff <= FCS_STROBE;
        FCS_STROBE: if (tick_end) state_ff <= FCS_HOLD;
        FCS_HOLD: if (tick_end) state_ff <= FCS_SAMPLE;
        FCS_SAMPLE: begin
          if (polling_ff) begin
            state_ff <= FCS_POLL;
          end else if (!last_step) begin
            step_ff  <= step_ff + 3'h1;
            state_ff <= FCS_LOOK;
          end else if (is_busy_op) begin
            // Device runs the algorithm alone from the last strobe rise
            // First poll read starts at once, so every poll check follows a real read
            polling_ff <= 1'b1;
            state_ff   <= FCS_SETUP;
          end else begin
            step_ff  <= 3'h0;
            state_ff <= FCS_IDLE;
          end
        end
        FCS_POLL: begin
          // Done when the toggle bit holds still across two reads
          if (have_prev_ff && !toggled) begin
            polling_ff <= 1'b0;
            step_ff    <= 3'h0;
            state_ff   <= FCS_IDLE;
          end else if (have_prev_ff && prev_lim_ff && rd_cap_ff[fcs_pkg::BIT_LIMIT]) begin
            polling_ff <= 1'b0;
            step_ff    <= 3'h0;
            state_ff   <= FCS_IDLE;
          end else begin
            state_ff <= FCS_SETUP;
          end
        end
        default: state_ff <= FCS_IDLE;
      endcase
    end
  end

  // Previous toggle bit for poll comparison
  always_ff @(posedge clk) begin
    // Limit bit must show on two toggling reads: the last status read may already show array data
    if (sys_rst || state_ff == FCS_IDLE) begin
      have_prev_ff <= 1'b0;
      prev_tog_ff  <= 1'b0;
      prev_lim_ff  <= 1'b0;
    end else if (state_ff == FCS_POLL) begin
      have_prev_ff <= 1'b1;
      prev_tog_ff  <= rd_cap_ff[fcs_pkg::BIT_TOGGLE];
      prev_lim_ff  <= rd_cap_ff[fcs_pkg::BIT_LIMIT];
    end
  end

  // Pin drive: address before strobe fall, data held past strobe rise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flash_addr_ff    <= '0;
      flash_dq_out_ff  <= '0;
      flash_dq_oe_n_ff <= 1'b1;
      flash_ce_n_ff    <= 1'b1;
      flash_oe_n_ff    <= 1'b1;
      flash_we_n_ff    <= 1'b1;
    end else begin
      unique case (state_ff)
        FCS_SETUP: begin
          // Poll reads reuse the last address, inside the busy sector
          if (!polling_ff) flash_addr_ff <= cyc.addr;
          flash_dq_out_ff  <= cyc.data;
          flash_dq_oe_n_ff <= !(cyc.is_write && !polling_ff);
          flash_ce_n_ff    <= 1'b0;
          flash_oe_n_ff    <= 1'b1;
          flash_we_n_ff    <= 1'b1;
        end
        FCS_STROBE: begin
          flash_we_n_ff <= !(cyc.is_write && !polling_ff);
          flash_oe_n_ff <= cyc.is_write && !polling_ff;
        end
        FCS_HOLD: begin
          flash_we_n_ff <= 1'b1;
          flash_oe_n_ff <= 1'b1;
        end
        FCS_IDLE: begin
          flash_dq_oe_n_ff <= 1'b1;
          flash_ce_n_ff    <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // Answer: read data captured when a read ends, done pulse at return to idle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_ff  <= 1'b0;
      fail_ff  <= 1'b0;
      rdata_ff <= '0;
    end else begin
      done_ff <= 1'b0;
      if (state_ff == FCS_SAMPLE && !cyc.is_write && !polling_ff) begin
        rdata_ff <= rd_cap_ff;
      end
      if (state_ff == FCS_SAMPLE && last_step && !polling_ff && !is_busy_op) begin
        done_ff <= 1'b1;
        fail_ff <= 1'b0;
      end else if (state_ff == FCS_POLL && have_prev_ff &&
                   (!toggled || (prev_lim_ff && rd_cap_ff[fcs_pkg::BIT_LIMIT]))) begin
        done_ff <= 1'b1;
        fail_ff <= toggled;
      end
    end
  end

  // Strobe low only inside a write phase
  we_phase_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(flash_we_n_ff) |-> $past(state_ff) == FCS_STROBE)
    else $error("write strobe fell outside strobe phase");
  // Address stable while strobe is low
  addr_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !flash_we_n_ff |-> $stable(flash_addr_ff))
    else $error("address moved during write strobe");
  // Data driven whenever strobe is low
  data_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
    !flash_we_n_ff |-> !flash_dq_oe_n_ff)
    else $error("data not driven during write");
  // No new request while polling
  busy_block_a: assert property (@(posedge clk) disable iff (sys_rst)
    polling_ff |-> !req_ready)
    else $error("request accepted while busy");
  // Never write and read at once
  oe_we_excl_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(!flash_we_n_ff && !flash_oe_n_ff))
    else $error("read and write enables both low");
  // Step counter stays below 6, the length of the longest sequence
  step_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff != FCS_IDLE && state_ff != FCS_LOOK |-> step_ff < 3'h6)
    else $error("step counter overran");
  // Done follows from sample or poll
  done_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
    done_ff |-> $past(state_ff) == FCS_SAMPLE || $past(state_ff) == FCS_POLL)
    else $error("done without finished sequence");
  // Back to idle after done
  idle_after_a: assert property (@(posedge clk) disable iff (sys_rst)
    done_ff |-> state_ff == FCS_IDLE)
    else $error("not idle after done");
endmodule : fcs_host

//--- bench/fcs_flash_model.sv
// Behavioural parallel flash device that answers the host sequencer
`timescale 1ns/1ps
module fcs_flash_model #(
  parameter logic [15:0] MAKER = 16'h005a,  // Arbitrary value
  parameter logic [15:0] DEVID = 16'h1234,  // Arbitrary value
  parameter int          BUSY  = 4
) (
  // Pins
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [16:0] addr,
  input  wire logic [15:0] dq,
  input  wire logic        byte_mode,
  // Fault control
  input  wire logic        limit_fail,
  // Read data wire
  output logic [15:0]      q
);
  logic [15:0] mem [0:131071];
  logic [16:0] a_lat, pa;
  logic [15:0] qv = 16'h0;
  logic [2:0]  step = 3'h0;
  logic        drv = 1'b0, tog = 1'b0, prog = 1'b0, ident = 1'b0;
  logic        erasing = 1'b0, susp = 1'b0, chip = 1'b0, failed = 1'b0;
  int          busy = 0;
  // Released bus shows the inverse so a stale sample never matches
  assign q = drv ? qv : ~qv;
  // Array starts erased
  initial for (int k = 0; k < 131072; k++) mem[k] = 16'hffff;
  function automatic logic [15:0] rd(input logic [16:0] a);
    return mem[a];
  endfunction : rd
  // Address on falling strobe, data on rising strobe
  always @(negedge we_n) if (!ce_n) a_lat = addr;
  always @(posedge we_n) begin
    logic [10:0] ua, ub, lo;
    logic [7:0]  d;
    logic        ok;
    ua = byte_mode ? fcs_pkg::BYTE_ADDR_A[10:0] : fcs_pkg::WORD_ADDR_A[10:0];
    ub = byte_mode ? fcs_pkg::BYTE_ADDR_B[10:0] : fcs_pkg::WORD_ADDR_B[10:0];
    lo = a_lat[10:0];
    d = dq[7:0];
    if (ce_n) begin
    end else if (busy > 0 && !susp && !(failed && d == fcs_pkg::CODE_RESET)) begin
      if (erasing && !chip && d == fcs_pkg::CODE_SUSPEND) susp = 1'b1;
    end else if (susp && d == fcs_pkg::CODE_RESUME) begin
      susp = 1'b0;
    end else if (d == fcs_pkg::CODE_RESET) begin
      step = 0; ident = 0; prog = 0; busy = 0; failed = 0; susp = 0; erasing = 0;
    end else if (prog) begin
      mem[a_lat] = dq; pa = a_lat; prog = 0; busy = BUSY; erasing = 0;
    end else begin
      case (step)
        3'h0, 3'h3: ok = lo == ua && d == fcs_pkg::CODE_UNLOCK1;
        3'h1, 3'h4: ok = lo == ub && d == fcs_pkg::CODE_UNLOCK2;
        3'h2: ok = lo == ua && (d == fcs_pkg::CODE_PROGRAM || d == fcs_pkg::CODE_IDENT || d == fcs_pkg::CODE_ERASE);
        default: ok = (lo == ua && (d == fcs_pkg::CODE_CHIP || d == fcs_pkg::CODE_PROTECT)) || d == fcs_pkg::CODE_SECTOR;
      endcase
      if (!ok) begin
        step = 0; ident = 0;
      end else if (step == 2 && d != fcs_pkg::CODE_ERASE) begin
        prog = d == fcs_pkg::CODE_PROGRAM; ident = d == fcs_pkg::CODE_IDENT; step = 0;
      end else if (step == 5) begin
        step = 0;
        if (d != fcs_pkg::CODE_PROTECT) begin
          // Pre-program and erase collapse to the erased value; both finish before polling ends
          chip = d == fcs_pkg::CODE_CHIP; erasing = 1; busy = BUSY; pa = a_lat;
          for (int k = 0; k < 131072; k++) if (chip || k[16:12] == a_lat[16:12]) mem[k] = 16'hffff;
        end
      end else step = step + 1;
    end
  end
  // Reads: status while busy and not suspended, identifier in ident mode, array otherwise
  always @(negedge oe_n) if (!ce_n && we_n) begin
    if (busy > 0 && !susp) begin
      tog = ~tog; qv = rd(pa); qv[7] = ~qv[7]; qv[6] = tog; qv[5] = limit_fail;
      failed = failed | limit_fail;
      if (!failed) busy = busy - 1;
    end else if (ident) begin
      if (addr[10:0] == fcs_pkg::PROT_VERIFY) qv = {15'h0, addr[16:12] == 5'h01};
      else qv = addr[0] ? DEVID : MAKER;
    end else qv = rd(addr);
    drv = 1'b1;
  end
  always @(posedge oe_n or posedge ce_n) drv = 1'b0;
endmodule : fcs_flash_model

//--- bench/tb_flash_command_sequencer.sv
// Self-checking bench for the flash host sequencer against a device model
`timescale 1ns/1ps
module tb_flash_command_sequencer;
  logic              clk, sys_rst, req_valid, lim, req_ready, done_ff, fail_ff;
  logic              dq_oe_n, ce_n, oe_n, we_n;
  fcs_pkg::fcs_req_t req;
  logic [15:0]       rdata_ff, dq_o, dq, mq, wd;
  logic [16:0]       fa, wa;
  int                num_errors = 0, num_checks = 0, wcnt = 0, w0;
  // Host drives the data wire only while its enable is low
  assign dq = !dq_oe_n ? dq_o : mq;
  fcs_host dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .done_ff(done_ff), .fail_ff(fail_ff), .rdata_ff(rdata_ff), .flash_addr_ff(fa), .flash_dq_out_ff(dq_o),
    .flash_dq_oe_n_ff(dq_oe_n), .flash_dq_in(dq), .flash_ce_n_ff(ce_n), .flash_oe_n_ff(oe_n),
    .flash_we_n_ff(we_n));
  fcs_flash_model #(.BUSY(4)) flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa), .dq(dq),
    .byte_mode(req.byte_mode), .limit_fail(lim), .q(mq));
  // Records every completed write on the pins
  always @(posedge we_n) if (!ce_n) begin
    wcnt++; wa = fa; wd = dq;
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task complete_run;
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One request, taken on a ready edge, then a bounded wait for done
  task automatic op(input fcs_pkg::fcs_op_t o, input logic b, input logic [16:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    #1 req = '{o, b, a, d};
    req_valid = 1'b1;
    w0 = wcnt;
    for (n = 0; req_ready !== 1'b1 && n < 100; n++) @(posedge clk) #1;
    if (n == 100) num_errors++;
    @(posedge clk);
    #1 req_valid = 1'b0;
    for (n = 0; done_ff !== 1'b1 && n < 5000; n++) @(posedge clk) #1;
    if (n == 5000) num_errors++;
  endtask : op
  task t_program;
    op(fcs_pkg::FCS_OP_PROGRAM, 1'b0, 17'h12345, 16'hbeef);
    chk(16'(wcnt - w0), 16'h0004);
    chk(wd, 16'hbeef);
    chk({15'h0, fail_ff}, 16'h0);
    op(fcs_pkg::FCS_OP_PROGRAM, 1'b1, 17'h00100, 16'h00a5);
    op(fcs_pkg::FCS_OP_READ, 1'b0, 17'h12345, 16'h0);
    chk(rdata_ff, 16'hbeef);
    op(fcs_pkg::FCS_OP_READ, 1'b1, 17'h00100, 16'h0);
    chk(rdata_ff, 16'h00a5);
  endtask : t_program
  task t_ident;
    op(fcs_pkg::FCS_OP_IDENT, 1'b0, 17'h00000, 16'h0);
    chk(rdata_ff, 16'h005a);
    op(fcs_pkg::FCS_OP_IDENT, 1'b0, 17'h00001, 16'h0);
    chk(rdata_ff, 16'h1234);
    op(fcs_pkg::FCS_OP_IDENT, 1'b0, 17'h01002, 16'h0);
    chk(rdata_ff, 16'h0001);
    op(fcs_pkg::FCS_OP_IDENT, 1'b0, 17'h02002, 16'h0);
    chk(rdata_ff, 16'h0000);
    op(fcs_pkg::FCS_OP_RESET, 1'b0, 17'h1abcd, 16'h0);
    chk({wd[7:0], 8'(wcnt - w0)}, 16'hf001);
  endtask : t_ident
  task t_sector_erase;
    op(fcs_pkg::FCS_OP_SECTOR_ERASE, 1'b0, 17'h12000, 16'h0);
    chk({wa[15:0]}, 16'h2000);
    chk({wd[7:0], 8'(wcnt - w0)}, 16'h3006);
    op(fcs_pkg::FCS_OP_READ, 1'b0, 17'h12345, 16'h0);
    chk(rdata_ff, 16'hffff);
    op(fcs_pkg::FCS_OP_READ, 1'b1, 17'h00100, 16'h0);
    chk(rdata_ff, 16'h00a5);
  endtask : t_sector_erase
  task t_suspend_resume;
    op(fcs_pkg::FCS_OP_SUSPEND, 1'b0, 17'h1fff0, 16'h0);
    chk({wd[7:0], 8'(wcnt - w0)}, 16'hb001);
    op(fcs_pkg::FCS_OP_RESUME, 1'b0, 17'h00aaa, 16'h0);
    chk({wd[7:0], 8'(wcnt - w0)}, 16'h3001);
  endtask : t_suspend_resume
  task t_chip_protect;
    op(fcs_pkg::FCS_OP_PROTECT_UNLOCK, 1'b0, 17'h0, 16'h0);
    chk({wd[7:0], 8'(wcnt - w0)}, 16'h2006);
    chk({5'h0, wa[10:0]}, 16'h0555);
    op(fcs_pkg::FCS_OP_CHIP_ERASE, 1'b0, 17'h0, 16'h0);
    chk({wd[7:0], 8'(wcnt - w0)}, 16'h1006);
    chk({5'h0, wa[10:0]}, 16'h0555);
    op(fcs_pkg::FCS_OP_READ, 1'b1, 17'h00100, 16'h0);
    chk(rdata_ff, 16'hffff);
  endtask : t_chip_protect
  task t_erase_limit;
    lim = 1'b1;
    op(fcs_pkg::FCS_OP_SECTOR_ERASE, 1'b0, 17'h03000, 16'h0);
    chk({15'h0, fail_ff}, 16'h0001);
    lim = 1'b0;
    op(fcs_pkg::FCS_OP_RESET, 1'b0, 17'h0, 16'h0);
    op(fcs_pkg::FCS_OP_PROGRAM, 1'b0, 17'h03004, 16'h5a5a);
    op(fcs_pkg::FCS_OP_READ, 1'b0, 17'h03004, 16'h0);
    chk(rdata_ff, 16'h5a5a);
  endtask : t_erase_limit
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    complete_run;
  end
  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    lim = 1'b0;
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    t_program;
    t_ident;
    t_sector_erase;
    t_suspend_resume;
    t_chip_protect;
    t_erase_limit;
    complete_run;
  end
endmodule : tb_flash_command_sequencer
